// File: epg_pkg.sv
// shared constants and carrier types of the eight channel modulator
// assumes a single bus clock domain and a synchronous reset
package epg_pkg;

  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int          CH_N      = 8;      // modulator channels
  localparam int          PAIR_N    = 4;      // concatenation pairs
  localparam int          BYTE_W    = 8;      // narrow channel width
  localparam int          CNT_W     = 16;     // counter width, wide mode
  localparam int          PRESC_W   = 7;      // bus clock prescaler
  localparam int          SCL_W     = 10;     // scaled clock divider
  localparam int          SIDE_N    = 2;      // clock sides a and b
  localparam logic [6:0]  PRESC_RST = 7'h00;
  localparam logic [9:0]  SCL_RST   = 10'h000;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [7:0]  BYTE_RST  = 8'h00;

  // ---------------------------------------------------------------
  // software controls, held outside the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] enable;       // per channel run
    logic [7:0] polarity;     // 1: duty portion high
    logic [7:0] clk_scaled;   // 1: scaled clock, 0: base clock
    logic [7:0] center;       // 1: centre aligned
    logic [3:0] concat;       // pair k joins channels 2k and 2k+1
    logic [2:0] prescale_a;   // base clock a = bus / 2^n
    logic [2:0] prescale_b;   // base clock b = bus / 2^n
    logic [7:0] scale_a;      // scaled clock a = a / (2*n), 0 -> 512
    logic [7:0] scale_b;      // scaled clock b = b / (2*n), 0 -> 512
    logic       wait_stop;    // halt prescaler in wait mode
    logic       freeze_stop;  // halt prescaler in freeze mode
    logic       shutdown_en;  // channel 7 pin becomes shutdown input
    logic       shutdown_lvl; // pin level that trips the shutdown
    logic [1:0] reserved;     // ignored
  } epg_cfg_t;

  // period and duty as written by software
  typedef struct packed {
    logic [7:0][7:0] period;
    logic [7:0][7:0] duty;
  } epg_wave_t;

  // state shown back to software
  typedef struct packed {
    logic [7:0][7:0] count;   // wide pair: odd high byte, even low
    logic [7:0]      running; // channel counting
    logic            stopped; // prescaler halted
    logic            tripped; // emergency shutdown active
    logic [5:0]      reserved;
  } epg_stat_t;

endpackage : epg_pkg

// File: epg_top.sv
// eight channel pulse width modulator with per channel counters
// assumes controls are static registers synchronous to clk_sys and
// that the pin inputs are already synchronous to clk_sys
// Functional notes
// RL1: eight channels, own counter, period, duty
// RL2: period and duty load at zero or disable
// RL3: left or centre alignment per channel
// RL4: independent enable for each channel
// RL5: per channel duty polarity select
// RL6: eight 8-bit or four 16-bit channels
// RL7: clocks a, b, scaled a, scaled b selectable
// RL8: duty settable from 0% to 100%
// RL9: wait mode option stops the prescaler
// RL10: freeze mode option stops the prescaler
// RL11: channel 7 pin doubles as shutdown input
// RL12: one output pin per channel
// RL13: reserved bits read zero, writes ignored
// RL14: pair joins even and odd, odd pin drives
`timescale 1ns/100ps
`default_nettype none

module epg_top
  import epg_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire epg_cfg_t  cfg,
  input  wire epg_wave_t wave,
  input  wire logic      wait_mode,
  input  wire logic      freeze_mode,
  input  wire logic      channel7_output_shutdown_pin_in,
  output logic           channel7_output_shutdown_pin_out,
  output logic           channel7_output_shutdown_pin_oe_n,
  output logic [6:0]     pwm_pin_q,
  output epg_stat_t      stat_q
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // low bits that must be all ones for a base clock tick
  function automatic logic [6:0] epg_mask(input logic [2:0] sel);
    return 7'((8'h01 << sel) - 8'h01);
  endfunction : epg_mask

  // scaled clock divide ratio, twice the setting, zero means 512
  function automatic logic [9:0] epg_top_ratio(input logic [7:0] s);
    return {(s == 8'h00), s, 1'b0};
  endfunction : epg_top_ratio

  logic [6:0]       presc_q;
  logic [1:0]       tick_b_q;          // base clock ticks a, b
  logic [1:0]       tick_s_q;          // scaled clock ticks a, b
  logic [9:0]       scl_q [SIDE_N];
  logic [15:0]      cnt_q [CH_N];
  logic [15:0]      cnt_d [CH_N];
  logic [15:0]      per_eff_q [CH_N];
  logic [15:0]      per_eff_d [CH_N];
  logic [15:0]      dty_eff_q [CH_N];
  logic [15:0]      dty_eff_d [CH_N];
  logic [7:0]       dir_q;
  logic [7:0]       dir_d;
  logic [7:0]       run_w;
  logic [7:0]       ch_tick;
  logic [7:0]       wave_d;
  logic [7:0]       pwm_q;
  logic             stop_w;
  logic             shut_w;

  // RL9 RL10 prescaler gating
  assign stop_w = (wait_mode && cfg.wait_stop) ||
                  (freeze_mode && cfg.freeze_stop);
  // RL11 shutdown trips on the pin level, only once the pin is released
  assign shut_w = cfg.shutdown_en && channel7_output_shutdown_pin_oe_n &&
                  (channel7_output_shutdown_pin_in == cfg.shutdown_lvl);

  // ---------------------------------------------------------------
  // clock sources
  // ---------------------------------------------------------------
  // RL9 RL10 prescaler holds while stopped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      presc_q <= PRESC_RST;
    end else if (!stop_w) begin
      presc_q <= 7'(presc_q + 7'h01);
    end
  end

  // RL7 base and scaled clock ticks for sides a and b
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_b_q <= 2'h0;
      tick_s_q <= 2'h0;
      for (int j = 0; j < SIDE_N; j++) begin
        scl_q[j] <= SCL_RST;
      end
    end else begin
      tick_b_q[0] <= !stop_w &&
        ((presc_q & epg_mask(cfg.prescale_a)) == epg_mask(cfg.prescale_a));
      tick_b_q[1] <= !stop_w &&
        ((presc_q & epg_mask(cfg.prescale_b)) == epg_mask(cfg.prescale_b));
      tick_s_q <= 2'h0;
      for (int j = 0; j < SIDE_N; j++) begin
        if (tick_b_q[j] && !stop_w) begin // held while stopped
          if (scl_q[j] >= 10'(epg_top_ratio(j == 0 ? cfg.scale_a
                                                   : cfg.scale_b)
                              - 10'h001)) begin
            scl_q[j]    <= SCL_RST;
            tick_s_q[j] <= 1'b1;
          end else begin
            scl_q[j] <= 10'(scl_q[j] + 10'h001);
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // channel counters
  // ---------------------------------------------------------------
  // RL1 RL6 RL14 next state of each channel counter
  always_comb begin
    logic        wide;
    logic        odd;
    logic [15:0] per_new;
    logic [15:0] dty_new;
    wide    = 1'b0;
    odd     = 1'b0;
    per_new = CNT_RST;
    dty_new = CNT_RST;
    for (int i = 0; i < CH_N; i++) begin
      wide = cfg.concat[i / 2];
      odd  = i[0];
      // RL14 odd channel takes the pair's high byte
      if (wide && odd) begin
        per_new = {wave.period[i], wave.period[i & 6]};
        dty_new = {wave.duty[i], wave.duty[i & 6]};
      end else begin
        per_new = {BYTE_RST, wave.period[i]};
        dty_new = {BYTE_RST, wave.duty[i]};
      end
      // RL4 RL14 even member of a pair stays idle
      run_w[i] = cfg.enable[i] && !(wide && !odd);
      // RL7 per channel source, channels 2,3,6,7 on side b
      ch_tick[i] = cfg.clk_scaled[i] ? tick_s_q[i[1]] : tick_b_q[i[1]];
      cnt_d[i]     = cnt_q[i];
      dir_d[i]     = dir_q[i];
      per_eff_d[i] = per_eff_q[i];
      dty_eff_d[i] = dty_eff_q[i];
      // RL2 disabled channel loads buffers at once
      if (!run_w[i]) begin
        cnt_d[i]     = CNT_RST;
        dir_d[i]     = 1'b0;
        per_eff_d[i] = per_new;
        dty_eff_d[i] = dty_new;
      end else if (ch_tick[i] && !stop_w) begin // frozen while stopped
        // RL3 centre aligned counts up to period and back
        if (cfg.center[i]) begin
          if (per_eff_q[i] == CNT_RST) begin
            per_eff_d[i] = per_new;
            dty_eff_d[i] = dty_new;
          end else if (!dir_q[i]) begin
            cnt_d[i] = 16'(cnt_q[i] + CNT_ONE);
            dir_d[i] = ({1'b0, cnt_q[i]} + 17'h00001) >=
                       {1'b0, per_eff_q[i]};
          end else if (cnt_q[i] > CNT_ONE) begin
            cnt_d[i] = 16'(cnt_q[i] - CNT_ONE);
          end else begin
            // RL2 reload when the count reaches zero, never below it
            cnt_d[i]     = CNT_RST;
            dir_d[i]     = 1'b0;
            per_eff_d[i] = per_new;
            dty_eff_d[i] = dty_new;
          end
        end else if (({1'b0, cnt_q[i]} + 17'h00001) >=
                     {1'b0, per_eff_q[i]}) begin
          // RL2 left aligned wraps to zero and reloads
          cnt_d[i]     = CNT_RST;
          per_eff_d[i] = per_new;
          dty_eff_d[i] = dty_new;
        end else begin
          cnt_d[i] = 16'(cnt_q[i] + CNT_ONE);
        end
      end
      // RL8 RL5 active while count below duty, polarity applied
      if (shut_w || !run_w[i] || cnt_q[i] >= dty_eff_q[i]) begin
        wave_d[i] = !cfg.polarity[i];
      end else begin
        wave_d[i] = cfg.polarity[i];
      end
    end
  end

  // RL1 counter and buffer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_q <= 8'h00;
      for (int i = 0; i < CH_N; i++) begin
        cnt_q[i]     <= CNT_RST;
        per_eff_q[i] <= CNT_RST;
        dty_eff_q[i] <= CNT_RST;
      end
    end else begin
      dir_q <= dir_d;
      for (int i = 0; i < CH_N; i++) begin
        cnt_q[i]     <= cnt_d[i];
        per_eff_q[i] <= per_eff_d[i];
        dty_eff_q[i] <= dty_eff_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // pins and status
  // ---------------------------------------------------------------
  // RL12 RL11 one pin per channel, pin 7 released for shutdown
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_q                             <= 8'h00;
      pwm_pin_q                         <= 7'h00;
      channel7_output_shutdown_pin_out  <= 1'b0;
      channel7_output_shutdown_pin_oe_n <= 1'b1;
    end else begin
      pwm_q                             <= wave_d;
      pwm_pin_q                         <= wave_d[6:0];
      channel7_output_shutdown_pin_out  <= wave_d[7];
      channel7_output_shutdown_pin_oe_n <= cfg.shutdown_en;
    end
  end

  // RL13 status readback, reserved bits forced to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        stat_q.count[i] <= !cfg.concat[i / 2] ? cnt_q[i][7:0] :
                           (i[0] ? cnt_q[i][15:8] : cnt_q[i | 1][7:0]);
      end
      stat_q.running  <= run_w;
      stat_q.stopped  <= stop_w;
      stat_q.tripped  <= shut_w;
      stat_q.reserved <= 6'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // no base tick, or stopped, leaves the scaled clock quiet
  sequence seq_idle_a;
    !tick_b_q[0] || stop_w;
  endsequence
  chk_wait_gate: assert property ( // RL9
    wait_mode && cfg.wait_stop |=> $stable(presc_q) && !tick_b_q[0])
    else $error("prescaler ran in wait mode");
  chk_freeze_gate: assert property ( // RL10
    freeze_mode && cfg.freeze_stop |=> $stable(presc_q) ##0 !tick_b_q[1])
    else $error("prescaler ran in freeze mode");
  chk_scaled_source: assert property ( // RL7
    seq_idle_a |=> !tick_s_q[0])
    else $error("scaled tick without base tick");
  chk_disabled_idle: assert property ( // RL4
    !cfg.enable[3] |=> cnt_q[3] == CNT_RST && !stat_q.running[3])
    else $error("disabled channel counting");
  chk_buffer_hold: assert property ( // RL2
    cfg.enable[0] && !cfg.concat[0] |=>
      cnt_q[0] == CNT_RST || $stable(per_eff_q[0]))
    else $error("period changed mid period");
  chk_duty_zero: assert property ( // RL8
    dty_eff_q[0] == CNT_RST |=> pwm_q[0] == !$past(cfg.polarity[0]))
    else $error("zero duty not inactive");
  chk_duty_full: assert property ( // RL8
    run_w[2] && !cfg.center[2] && !shut_w && dty_eff_q[2] >= per_eff_q[2]
      && per_eff_q[2] != CNT_RST && cnt_q[2] < per_eff_q[2]
      |=> pwm_q[2] == $past(cfg.polarity[2]))
    else $error("full duty not active");
  chk_center_range: assert property ( // RL3
    run_w[1] && cfg.center[1] && $past(run_w[1] && cfg.center[1]) &&
      $stable(per_eff_q[1]) && per_eff_q[1] != CNT_RST
      |-> cnt_q[1] <= per_eff_q[1])
    else $error("centre count beyond period");
  chk_pin_release: assert property ( // RL11
    cfg.shutdown_en |=> channel7_output_shutdown_pin_oe_n)
    else $error("shutdown pin still driven");
  chk_shutdown_force: assert property ( // RL11
    shut_w |=> pwm_q == ~$past(cfg.polarity))
    else $error("outputs not forced inactive");
  chk_pair_idle: assert property ( // RL14
    cfg.concat[0] |=> cnt_q[0] == CNT_RST ##0
      pwm_pin_q[0] == !$past(cfg.polarity[0]))
    else $error("even member of pair active");

endmodule : epg_top

`default_nettype wire

// File: epg_load.sv
// load model on the shared channel 7 pin, with a shutdown source
// assumes the bench commands when the source trips and at what level
`timescale 1ns/100ps
`default_nettype none

module epg_load (
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic trip,
  input  wire logic trip_lvl,
  output logic      pin_in
);
  // shared pin level
  // a released pin is driven by the source, idle at the inverse level
  assign pin_in = !pin_oe_n ? pin_out : (trip ? trip_lvl : !trip_lvl);
endmodule : epg_load

`default_nettype wire

// File: epg_top_tb.sv
// self-checking bench for the eight channel modulator
// assumes epg_pkg, epg_top and epg_load are compiled first
`timescale 1ns/100ps
`default_nettype none

module epg_top_tb import epg_pkg::*;;
  logic            clk_sys;
  logic            rst;
  logic            wait_mode;
  logic            freeze_mode;
  logic            trip;
  logic            pin_in;
  logic            pin_out;
  logic            oe_n;
  logic            seen;
  logic [6:0]      pins;
  logic [7:0][7:0] held;
  epg_cfg_t        cfg;
  epg_wave_t       wave;
  epg_stat_t       stat;
  int              fails;
  int              checked;
  int              act[8];
  int              rise[8];
  int              p[8];
  int              d[8];

  epg_top DUT (
    .clk_sys                          (clk_sys),
    .rst                              (rst),
    .cfg                              (cfg),
    .wave                             (wave),
    .wait_mode                        (wait_mode),
    .freeze_mode                      (freeze_mode),
    .channel7_output_shutdown_pin_in  (pin_in),
    .channel7_output_shutdown_pin_out (pin_out),
    .channel7_output_shutdown_pin_oe_n(oe_n),
    .pwm_pin_q                        (pins),
    .stat_q                           (stat)
  );

  epg_load load (
    .pin_out (pin_out),
    .pin_oe_n(oe_n),
    .trip    (trip),
    .trip_lvl(cfg.shutdown_lvl),
    .pin_in  (pin_in)
  );

  // ---------------------------------------------------------------
  // clock, watchdog and helpers
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen_v,
                       input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp_v, seen_v);
    end
  endtask : check

  // inputs change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : tick

  // high cycles and rising edges of every pin over n cycles
  task automatic measure(input int n);
    logic [7:0] prev;
    logic [7:0] now;
    prev = {pin_out, pins};
    act = '{default: 0};
    rise = '{default: 0};
    repeat (n) begin
      tick(1);
      now = {pin_out, pins};
      for (int i = 0; i < 8; i++) begin
        act[i] += now[i];
        rise[i] += now[i] & !prev[i];
      end
      prev = now;
    end
  endtask : measure

  function automatic int exp_high(int n, int pr, int du, bit c, bit e,
                                  bit pol);
    int a;
    if (!e || du == 0) a = 0;
    else if (c) a = (du > pr) ? n : n / (2 * pr) * (2 * du - 1);
    else a = (du >= pr) ? n : n / pr * du;
    return pol ? a : n - a;
  endfunction : exp_high

  function automatic int exp_rise(int n, int pr, int du, bit c, bit e);
    if (!e || du == 0 || du > pr || (!c && du == pr)) return 0;
    return c ? n / (2 * pr) : n / pr;
  endfunction : exp_rise

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cfg = '0;
    wave = '0;
    wait_mode = 1'b0;
    freeze_mode = 1'b0;
    trip = 1'b0;
    void'($urandom(32'hBDC71F33));
    tick(8);
    check("reset pins", {oe_n, pin_out, pins}, 9'h100);
    rst = 1'b0;
    // random channel mixes, all at full bus rate
    repeat (6) begin
      cfg = '0;
      tick(1);
      cfg.reserved = 2'($urandom);
      cfg.polarity = 8'($urandom);
      cfg.center = 8'($urandom);
      for (int i = 0; i < 8; i++) begin
        p[i] = 2 << ($urandom % 3);
        d[i] = $urandom % (p[i] + 2);
        if (cfg.center[i] && d[i] == p[i]) d[i]++;
        wave.period[i] = 8'(p[i]);
        wave.duty[i] = 8'(d[i]);
      end
      tick(1);
      cfg.enable = 8'($urandom);
      tick(20);
      measure(64);
      for (int i = 0; i < 8; i++) begin
        check("high", act[i], exp_high(64, p[i], d[i], cfg.center[i],
              cfg.enable[i], cfg.polarity[i]));
        check("edges", rise[i], exp_rise(64, p[i], d[i],
              cfg.center[i], cfg.enable[i]));
      end
      check("reserved", stat.reserved, 6'h00);
      check("running", stat.running, cfg.enable);
    end
    // pair 0 joined, period 0x0102 and duty 0x0081
    cfg = '0;
    tick(1);
    cfg.concat = 4'h1;
    cfg.polarity = 8'h03;
    wave.period[1:0] = {8'h01, 8'h02};
    wave.duty[1:0] = {8'h00, 8'h81};
    tick(1);
    cfg.enable = 8'h03;
    tick(300);
    measure(516);
    check("wide high", act[1], 258);
    check("wide edges", rise[1], 2);
    check("even pin idle", act[0], 0);
    // base a over 4, scaled a over 16, base b over 2, scaled b over 4
    cfg = '0;
    tick(1);
    cfg.prescale_a = 3'h2;
    cfg.prescale_b = 3'h1;
    cfg.clk_scaled = 8'h06;
    cfg.scale_a = 8'h02;
    cfg.scale_b = 8'h01;
    cfg.polarity = 8'hFF;
    wave.period = {8{8'h04}};
    wave.duty = {8{8'h01}};
    tick(1);
    cfg.enable = 8'h0F;
    tick(40);
    measure(64);
    check("clock a edges", rise[0], 4);
    check("clock a high", act[0], 16);
    check("scaled b edges", rise[2], 4);
    check("scaled a edges", rise[1], 1);
    check("scaled a high", act[1], 16);
    check("base b edges", rise[3], 8);
    // new period waits for the wrap of the old one
    cfg.prescale_a = 3'h0;
    wave.period[0] = 8'h08;
    tick(20);
    for (int k = 0; k < 20 && stat.count[0] !== 8'h03; k++) tick(1);
    wave.period[0] = 8'h02;
    seen = 1'b0;
    for (int k = 0; k < 8; k++) begin
      tick(1);
      seen |= stat.count[0] === 8'h07;
    end
    check("old period kept", seen, 1);
    tick(4);
    seen = 1'b0;
    for (int k = 0; k < 16; k++) begin
      tick(1);
      seen |= stat.count[0] > 8'h01;
    end
    check("new period", seen, 0);
    // wait and freeze options halt the counters
    cfg.wait_stop = 1'b1;
    cfg.freeze_stop = 1'b1;
    wait_mode = 1'b1;
    tick(2);
    held = stat.count;
    tick(20);
    check("wait stopped", stat.stopped, 1);
    check("wait held", stat.count === held, 1);
    wait_mode = 1'b0;
    freeze_mode = 1'b1;
    tick(2);
    held = stat.count;
    tick(20);
    check("freeze held", stat.count === held, 1);
    cfg.freeze_stop = 1'b0;
    tick(3);
    check("freeze runs", stat.stopped, 0);
    freeze_mode = 1'b0;
    // shutdown through the channel 7 pin
    cfg.polarity = 8'h5A;
    cfg.shutdown_en = 1'b1;
    cfg.shutdown_lvl = 1'b1;
    tick(2);
    check("pin released", oe_n, 1);
    check("not tripped", stat.tripped, 0);
    trip = 1'b1;
    tick(2);
    check("tripped", stat.tripped, 1);
    check("forced pins", {pin_out, pins}, 8'hA5);
    test_done();
  end
endmodule : epg_top_tb

`default_nettype wire
